// [bench/smp_mem_model.sv]
// 16-bit asynchronous and burst memory on the far side of the port
// assumes registered controller pins on ref_clk_in
module smp_mem_model
  import smp_pkg::*;
(
  input wire logic clk_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic data_oe_in,
  input wire logic oe_n_in,
  input wire logic wr_n_in,
  input wire logic [LANES-1:0] lanes_n_in,
  input wire logic [BANKS-1:0] bank_n_in,
  input wire logic stall_rdy_in,
  input wire logic stall_wait_in,
  output logic [DATA_W-1:0] data_out,
  output logic ready_out,
  output logic wait_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last_reg;
  wire sel = bank_n_in != BANKS_IDLE_N;
  // wire level: controller, memory, else a changing pattern
  assign data_out = data_oe_in ? data_in :
    (sel && !oe_n_in) ? mem[addr_in[3:0]] : ~last_reg;
  // flow control lines held back on command
  assign ready_out = !stall_rdy_in;
  assign wait_out = stall_wait_in;
  initial
  begin
    last_reg = 16'h0;
    foreach (mem[i]) mem[i] = 16'h5a00 + 16'(i);
  end
  // byte-wise store while the write strobe is low
  always @(posedge clk_in)
  begin
    last_reg <= data_out;
    if (sel && !wr_n_in && !lanes_n_in[0])
      mem[addr_in[3:0]][7:0] <= data_in[7:0];
    if (sel && !wr_n_in && !lanes_n_in[1])
      mem[addr_in[3:0]][15:8] <= data_in[15:8];
  end
endmodule

// [bench/smp_top_monitor.sv]
// pin-level checker for the static memory port
// bound onto smp_top, sees only its ports
module smp_top_monitor
  import smp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_burst_in,
  input wire logic [LANES-1:0] req_lanes_in,
  input wire logic req_ready_out,
  input wire logic pins_oe_out,
  input wire logic mem_data_oe_out,
  input wire logic [LANES-1:0] byte_lane_enable_n_out,
  input wire logic [BANKS-1:0] bank_select_n_out,
  input wire logic output_enable_strobe_n_out,
  input wire logic read_strobe_n_out,
  input wire logic write_strobe_n_out,
  input wire logic ext_bus_request_in,
  input wire logic ext_bus_granted_out,
  input wire logic grant_hang_out,
  input wire logic burst_clock_out,
  input wire logic burst_data_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence rd_setup_s;
    (!output_enable_strobe_n_out && read_strobe_n_out) [*2];
  endsequence
  sequence rd_access_s;
    !output_enable_strobe_n_out && !read_strobe_n_out;
  endsequence
  // strobe sequences and write byte lanes after a request is taken
  rd_order_a: assert property (
    req_ready_out && !req_write_in && !req_burst_in
    |-> rd_setup_s ##1 rd_access_s)
    else $error("read strobe order wrong");
  wr_strobe_a: assert property (
    req_ready_out && req_write_in |-> write_strobe_n_out [*2]
    ##1 !write_strobe_n_out [*3] ##1 write_strobe_n_out)
    else $error("write strobe length wrong");
  wr_lane_a: assert property (
    req_ready_out && req_write_in |-> byte_lane_enable_n_out == ~req_lanes_in)
    else $error("byte lanes wrong");
  // idle and arbitration pins
  idle_quiet_a: assert property (
    pins_oe_out && bank_select_n_out == BANKS_IDLE_N
    |-> output_enable_strobe_n_out && read_strobe_n_out
    && write_strobe_n_out && byte_lane_enable_n_out == LANES_IDLE_N)
    else $error("strobe active while idle");
  bus_float_a: assert property (
    ext_bus_granted_out |-> !pins_oe_out && !mem_data_oe_out)
    else $error("pins driven while granted");
  grant_cause_a: assert property (
    $rose(ext_bus_granted_out) |-> $past(ext_bus_request_in, 2))
    else $error("grant without request");
  grant_hang_a: assert property (
    (ext_bus_granted_out && req_valid_in) [*2] |-> grant_hang_out)
    else $error("hang missing");
  // burst setup phase
  bclk_toggle_a: assert property (
    burst_data_valid_out ##1 burst_data_valid_out
    |-> burst_clock_out != $past(burst_clock_out))
    else $error("burst clock stuck");
  burst_valid_a: assert property (
    $rose(burst_data_valid_out)
    |-> burst_data_valid_out [*2] ##1 !burst_data_valid_out)
    else $error("data valid length wrong");
endmodule
bind smp_top smp_top_monitor monitor_inst (.*);

// [bench/smp_top_test.sv]
// self-checking bench for the static memory port
// assumes smp_mem_model on the pins and the bound checker
module smp_top_test
  import smp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 0, rst_in = 1, ce_in = 1, req_valid_in = 0;
  logic req_write_in = 0, req_burst_in = 0, ext_bus_request_in = 0;
  logic [ADDR_W-1:0] req_addr_in = 24'h0, mem_addr_out;
  logic [DATA_W-1:0] req_wdata_in = 16'h0, rsp_rdata_out;
  logic [DATA_W-1:0] mem_data_in, mem_data_out;
  logic [LANES-1:0] req_lanes_in = 2'h3, byte_lane_enable_n_out;
  logic [BANK_W-1:0] req_bank_in = 2'h0;
  logic [BANKS-1:0] bank_select_n_out;
  logic req_ready_out, rsp_valid_out, mem_data_oe_out, pins_oe_out;
  logic output_enable_strobe_n_out, read_strobe_n_out, write_strobe_n_out;
  logic async_ready_in, ext_bus_granted_out, grant_hang_out;
  logic burst_clock_out, burst_data_valid_out, burst_wait_in;
  logic rdy_stall = 0, wait_stall = 0;
  int num_errors = 0, samples_checked = 0, n;
  wire [3:0] evt = {grant_hang_out, ext_bus_granted_out, rsp_valid_out,
    req_ready_out};
  typedef struct {logic wr; logic [1:0] ln; logic [3:0] a;
    logic [15:0] d;} smp_row_t;
  // writes by lane, then read back and an untouched word
  smp_row_t rows [5] = '{'{1, 2'h3, 4'h1, 16'habcd},
    '{1, 2'h2, 4'h1, 16'h12ff}, '{1, 2'h1, 4'h1, 16'hff34},
    '{0, 2'h3, 4'h1, 16'h1234}, '{0, 2'h3, 4'h2, 16'h5a02}};
  smp_top uut (.*);
  smp_mem_model mem_model (.clk_in(ref_clk_in), .addr_in(mem_addr_out),
    .data_in(mem_data_out), .data_oe_in(mem_data_oe_out),
    .oe_n_in(output_enable_strobe_n_out), .wr_n_in(write_strobe_n_out),
    .lanes_n_in(byte_lane_enable_n_out), .bank_n_in(bank_select_n_out),
    .stall_rdy_in(rdy_stall), .stall_wait_in(wait_stall),
    .data_out(mem_data_in),
    .ready_out(async_ready_in), .wait_out(burst_wait_in));
  // 25 MHz block clock
  always #20 ref_clk_in = ~ref_clk_in;
  task automatic chk(string name, logic [ADDR_W-1:0] seen,
    logic [ADDR_W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for one of the handshake events
  task automatic wait_sig(int which);
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk_in);
      k++;
    end
    while (evt[which] !== 1'b1 && k < 300);
    if (k >= 300)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic count_rsp(int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(posedge ref_clk_in);
      c += int'(rsp_valid_out === 1'b1);
    end
  endtask
  // one request held until taken
  task automatic req(logic wr, logic bst, logic [1:0] ln, logic [3:0] a,
    logic [15:0] d);
    @(posedge ref_clk_in);
    {req_valid_in, req_write_in, req_burst_in, req_lanes_in} <=
      {1'b1, wr, bst, ln};
    req_addr_in <= {20'h0, a};
    req_wdata_in <= d;
    wait_sig(0);
    req_valid_in <= 1'b0;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("idle pins", {pins_oe_out, bank_select_n_out,
      output_enable_strobe_n_out, read_strobe_n_out, write_strobe_n_out,
      byte_lane_enable_n_out}, 10'h3ff);
    foreach (rows[i])
    begin
      req_bank_in <= i[1:0];
      req(rows[i].wr, 1'b0, rows[i].ln, rows[i].a, rows[i].d);
      if (!rows[i].wr) wait_sig(1);
      if (!rows[i].wr)
        chk("read data", rsp_rdata_out, rows[i].d);
    end
    // memory not ready: access must not finish
    rdy_stall <= 1'b1;
    req(1'b0, 1'b0, 2'h3, 4'h2, 16'h0);
    count_rsp(14, n);
    chk("stalled read", {n[3:0], read_strobe_n_out}, 5'h0);
    rdy_stall <= 1'b0;
    wait_sig(1);
    chk("stalled data", rsp_rdata_out, 16'h5a02);
    // burst read held by wait, then four beats
    wait_stall <= 1'b1;
    req(1'b0, 1'b1, 2'h3, 4'h4, 16'h0);
    count_rsp(10, n);
    chk("burst wait", n, 0);
    wait_stall <= 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      wait_sig(1);
      chk("burst data", rsp_rdata_out, 16'h5a04 + 16'(b));
    end
    // external master takes the buses, then a read waits until they return
    ext_bus_request_in <= 1'b1;
    wait_sig(2);
    chk("floated pins", {pins_oe_out, mem_data_oe_out}, 2'h0);
    {req_valid_in, req_write_in, req_burst_in, req_addr_in} <= {3'h4, 24'h3};
    wait_sig(3);
    chk("refused request", req_ready_out, 1'b0);
    ext_bus_request_in <= 1'b0;
    wait_sig(0);
    req_valid_in <= 1'b0;
    wait_sig(1);
    chk("returned read", rsp_rdata_out, 16'h5a03);
    tally_and_finish();
  end
endmodule

// [src/smp_pkg.sv]
// shared constants and state encoding for the static memory port
// assumes a 25 MHz block clock and 16-bit asynchronous or burst memories
package smp_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int CNT_W = 4;
  localparam int CLK_PERIOD_NS = 40;
  // strobe phase lengths in ns and derived cycle counts (least times)
  localparam int SETUP_NS = 80;
  localparam int ACCESS_NS = 120;
  localparam int HOLD_NS = 40;
  localparam logic [CNT_W-1:0] SETUP_CYC =
    CNT_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC =
    CNT_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // beats in one synchronous burst read
  localparam logic [CNT_W-1:0] BURST_BEATS = 4'h4;
  // cycles a beat waits after the previous one, so that the data
  // for the new address has come through both input flops
  localparam logic [CNT_W-1:0] BEAT_GAP_CYC = 4'h2;
  // pin and synchroniser values after reset
  localparam logic [LANES-1:0] LANES_IDLE_N = 2'h3;
  localparam logic [BANKS-1:0] BANKS_IDLE_N = 4'hf;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [6:0] {
    SMP_IDLE    = 7'h01,
    SMP_SETUP   = 7'h02,
    SMP_ACCESS  = 7'h04,
    SMP_HOLD    = 7'h08,
    SMP_BSETUP  = 7'h10,
    SMP_BXFER   = 7'h20,
    SMP_GRANTED = 7'h40
  } smp_state_t;
endpackage

// [src/smp_sync.sv]
// two-flop synchronisers for every pin input of the memory port
// assumes the pins are asynchronous to ref_clk_in
module smp_sync
  import smp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic async_ready_in,
  input wire logic burst_wait_in,
  input wire logic ext_bus_request_in,
  input wire logic [DATA_W-1:0] mem_data_in,
  smp_sync_if.src sy
);
  logic [1:0] ready_reg;
  logic [1:0] wait_reg;
  logic [1:0] req_reg;
  logic [DATA_W-1:0] data1_reg;
  logic [DATA_W-1:0] data2_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ready_reg <= SYNC_RESET;
      wait_reg <= SYNC_RESET;
      req_reg <= SYNC_RESET;
      data1_reg <= '0;
      data2_reg <= '0;
    end
    else if (ce_in)
    begin
      ready_reg <= {ready_reg[0], async_ready_in};
      wait_reg <= {wait_reg[0], burst_wait_in};
      req_reg <= {req_reg[0], ext_bus_request_in};
      data1_reg <= mem_data_in;
      data2_reg <= data1_reg;
    end
  end

  // second stage outputs
  assign sy.ready = ready_reg[1];
  assign sy.wait_s = wait_reg[1];
  assign sy.request = req_reg[1];
  assign sy.data = data2_reg;
endmodule

// [src/smp_sync_if.sv]
// synchronised pin inputs passed from the synchroniser to the controller
// assumes both ends run on the same block clock
interface smp_sync_if;
  import smp_pkg::*;
  logic ready;
  logic wait_s;
  logic request;
  logic [DATA_W-1:0] data;
  modport src (output ready, output wait_s, output request, output data);
  modport dst (input ready, input wait_s, input request, input data);
endinterface

// [src/smp_top.sv]
// static memory port: strobe sequencer, burst reader and bus arbiter
// assumes a single-word request port from on-chip logic on ref_clk_in
// Contract
// R01: upper-byte write drives upper lane enable low, lower lane high.
// R02: lower-byte write drives upper lane enable high, lower lane low.
// R03: read output enable asserts at the start of the setup period.
// R04: read strobe asserts at the start of each read access period.
// R05: write strobe held for the whole access period, then released.
// R06: access does not advance while the memory reports not ready.
// R07: external master holds bus request while it needs the buses.
// R08: bus grant output tells the external master it owns the buses.
// R09: grant hang asserts when granted away and a transaction waits.
// R10: burst mode drives a dedicated burst clock to the memory.
// R11: burst data valid held through the whole burst read setup.
// R12: burst transfers stall while the memory signals wait.
// R13: while granted, address, data, strobes and selects float.
// R14: active-low strobes and selects stay deasserted when idle.
module smp_top
  import smp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_burst_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  input wire logic [LANES-1:0] req_lanes_in,
  input wire logic [BANK_W-1:0] req_bank_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_out,
  input wire logic [DATA_W-1:0] mem_data_in,
  output logic pins_oe_out,
  output logic [LANES-1:0] byte_lane_enable_n_out,
  output logic [BANKS-1:0] bank_select_n_out,
  output logic output_enable_strobe_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  input wire logic async_ready_in,
  input wire logic ext_bus_request_in,
  output logic ext_bus_granted_out,
  output logic grant_hang_out,
  output logic burst_clock_out,
  output logic burst_data_valid_out,
  input wire logic burst_wait_in
);
  smp_sync_if sy ();

  smp_state_t state_reg;
  smp_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] beat_reg;
  logic [CNT_W-1:0] beat_next;
  logic write_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [LANES-1:0] lanes_reg;
  logic [BANK_W-1:0] bank_reg;
  logic take;
  logic capture;
  logic bclk_reg;
  logic data_oe_reg;
  logic pins_oe_reg;
  logic [LANES-1:0] lanes_n_reg;
  logic [BANKS-1:0] bank_n_reg;
  logic oe_n_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  logic granted_reg;
  logic hang_reg;
  logic dv_reg;
  logic ready_reg;
  logic rsp_reg;
  logic [DATA_W-1:0] rdata_reg;

  smp_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_ready_in(async_ready_in),
    .burst_wait_in(burst_wait_in),
    .ext_bus_request_in(ext_bus_request_in),
    .mem_data_in(mem_data_in),
    .sy(sy)
  );

  // one-hot bank select, active low
  function automatic logic [BANKS-1:0] bank_dec_n(input logic [BANK_W-1:0] b);
    bank_dec_n = ~(BANKS'(1) << b);
  endfunction

  // sequencer: phase counts, ready and wait stalls, arbitration
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    beat_next = beat_reg;
    addr_next = addr_reg;
    take = 1'b0;
    capture = 1'b0;
    case (state_reg)
      SMP_IDLE:
      begin
        if (sy.request)
          state_next = SMP_GRANTED; // [R08]
        else if (req_valid_in && !ready_reg)
        begin
          take = 1'b1;
          addr_next = req_addr_in;
          cnt_next = SETUP_CYC - 4'h1;
          if (req_burst_in && !req_write_in)
            state_next = SMP_BSETUP;
          else
            state_next = SMP_SETUP;
        end
      end
      SMP_SETUP:
      begin
        if (cnt_reg == '0)
        begin
          state_next = SMP_ACCESS;
          cnt_next = ACCESS_CYC - 4'h1;
        end
        else
          cnt_next = cnt_reg - 4'h1;
      end
      SMP_ACCESS:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 4'h1;
        else if (sy.ready) // [R06]
        begin
          state_next = SMP_HOLD;
          cnt_next = HOLD_CYC - 4'h1;
          capture = !write_reg;
        end
      end
      SMP_HOLD:
      begin
        if (cnt_reg == '0)
          state_next = SMP_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      SMP_BSETUP:
      begin
        beat_next = '0;
        if (cnt_reg == '0)
          state_next = SMP_BXFER;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      SMP_BXFER:
      begin
        if (cnt_reg != '0)
          cnt_next = cnt_reg - 4'h1; // let the new address settle
        else if (bclk_reg && !sy.wait_s) // [R12]
        begin
          capture = 1'b1;
          addr_next = addr_reg + ADDR_W'(1);
          beat_next = beat_reg + 4'h1;
          cnt_next = BEAT_GAP_CYC;
          if (beat_reg == BURST_BEATS - 4'h1)
          begin
            state_next = SMP_HOLD;
            cnt_next = HOLD_CYC - 4'h1;
          end
        end
      end
      SMP_GRANTED:
      begin
        if (!sy.request) // [R07]
          state_next = SMP_IDLE;
      end
      default:
        state_next = SMP_IDLE;
    endcase
  end

  // pin decode from the next state, registered below
  wire wr_sel = take ? req_write_in : write_reg;
  wire [LANES-1:0] lanes_sel = take ? req_lanes_in : lanes_reg;
  wire [BANK_W-1:0] bank_sel = take ? req_bank_in : bank_reg;
  wire async_act = (state_next == SMP_SETUP) || (state_next == SMP_ACCESS);
  wire burst_act = (state_next == SMP_BSETUP) || (state_next == SMP_BXFER);
  wire cycle_act = async_act || burst_act || (state_next == SMP_HOLD);
  wire oe_n_next = !(!wr_sel && (async_act || burst_act)); // [R03]
  wire rd_n_next = !(!wr_sel && state_next == SMP_ACCESS); // [R04]
  wire wr_n_next = !(wr_sel && state_next == SMP_ACCESS); // [R05]
  wire [LANES-1:0] lanes_n_next =
    !cycle_act ? LANES_IDLE_N : // [R14]
    (wr_sel ? ~lanes_sel : '0); // [R01] [R02]
  wire [BANKS-1:0] bank_n_next =
    cycle_act ? bank_dec_n(bank_sel) : BANKS_IDLE_N; // [R14]
  wire granted_next = state_next == SMP_GRANTED;
  wire hang_next = granted_next && req_valid_in; // [R09]

  // state, counters and request capture
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= SMP_IDLE;
      cnt_reg <= '0;
      beat_reg <= '0;
      addr_reg <= '0;
      write_reg <= 1'b0;
      wdata_reg <= '0;
      lanes_reg <= '0;
      bank_reg <= '0;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      beat_reg <= beat_next;
      addr_reg <= addr_next;
      if (take)
      begin
        write_reg <= req_write_in;
        wdata_reg <= req_wdata_in;
        lanes_reg <= req_lanes_in;
        bank_reg <= req_bank_in;
      end
    end
  end

  // registered pins and user answers
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      bclk_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      pins_oe_reg <= 1'b1;
      lanes_n_reg <= LANES_IDLE_N;
      bank_n_reg <= BANKS_IDLE_N;
      oe_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      granted_reg <= 1'b0;
      hang_reg <= 1'b0;
      dv_reg <= 1'b0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else if (ce_in)
    begin
      bclk_reg <= burst_act ? !bclk_reg : 1'b0; // [R10]
      data_oe_reg <= wr_sel && cycle_act;
      pins_oe_reg <= !granted_next; // [R13]
      lanes_n_reg <= lanes_n_next;
      bank_n_reg <= bank_n_next;
      oe_n_reg <= oe_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      granted_reg <= granted_next; // [R08]
      hang_reg <= hang_next;
      dv_reg <= state_next == SMP_BSETUP; // [R11]
      ready_reg <= take;
      rsp_reg <= capture;
      if (capture)
        rdata_reg <= sy.data;
    end
  end

  // outputs straight from flops
  assign req_ready_out = ready_reg;
  assign rsp_valid_out = rsp_reg;
  assign rsp_rdata_out = rdata_reg;
  assign mem_addr_out = addr_reg;
  assign mem_data_out = wdata_reg;
  assign mem_data_oe_out = data_oe_reg;
  assign pins_oe_out = pins_oe_reg;
  assign byte_lane_enable_n_out = lanes_n_reg;
  assign bank_select_n_out = bank_n_reg;
  assign output_enable_strobe_n_out = oe_n_reg;
  assign read_strobe_n_out = rd_n_reg;
  assign write_strobe_n_out = wr_n_reg;
  assign ext_bus_granted_out = granted_reg;
  assign grant_hang_out = hang_reg;
  assign burst_clock_out = bclk_reg;
  assign burst_data_valid_out = dv_reg;
endmodule
